//--- pulse_counter_control_regs.sv
// Pulse counter with its control, command and flag registers on AXI4-Lite.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps

module pulse_counter_control_regs #(
  parameter int LF_DIVIDE = pulse_counter_pkg::LF_DIV
) (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        primary_input_in,
  input  wire logic        secondary_input_in,
  input  wire logic [31:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [31:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in
);

  localparam int AW = pulse_counter_pkg::ADDR_W;
  localparam int CW = pulse_counter_pkg::CNT_W;
  localparam int FW = pulse_counter_pkg::FLAG_W;
  localparam int RW = pulse_counter_pkg::ROUTE_W;
  localparam int TW = pulse_counter_pkg::CTRL_W;

  // The divider counter is 16 bits wide and needs at least two states.
  if (LF_DIVIDE < 2 || LF_DIVIDE > 65535) begin : g_bad_divide
    $error("LF_DIVIDE must lie between 2 and 65535.");
  end

  // ----------------------------------------------------------------------
  // Functions.
  // ----------------------------------------------------------------------
  // Merges a bus write into a word under its byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Tells whether a relative offset names a register of the map.
  function automatic logic mapped(input logic [AW-1:0] a);
    return (a <= pulse_counter_pkg::OFS_SYNC_BUSY) && (a[1:0] == 2'h0);
  endfunction

  // ----------------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------------
  pulse_counter_pkg::ctrl_s ctrl;
  logic [CW-1:0]     top_buffer;
  logic [CW-1:0]     top_value;
  logic [CW-1:0]     count;
  logic [FW-1:0]     irq_flags;
  logic [FW-1:0]     irq_enable;
  logic [pulse_counter_pkg::ROUTE_W-1:0] pin_routing;
  logic              freeze;
  logic              dir_status;
  logic              dom_rst;
  logic [1:0]        release_cnt;

  // ----------------------------------------------------------------------
  // AXI4-Lite write channel.
  // ----------------------------------------------------------------------
  logic [AW-1:0] wr_addr;
  logic [31:0]   wr_data;
  logic [3:0]    wr_strb;
  logic          aw_full;
  logic          w_full;
  logic          wr_fire;
  logic [31:0]   wr_word;

  assign wr_fire = aw_full && w_full && !s_axi_bvalid_out;
  assign wr_word = wr_data & {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                              {8{wr_strb[1]}}, {8{wr_strb[0]}}};

  // Address and data are taken independently, in either order.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      aw_full           <= 1'b0;
      w_full            <= 1'b0;
      wr_addr           <= '0;
      wr_data           <= '0;
      wr_strb           <= '0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        wr_addr           <= s_axi_awaddr_in[AW-1:0];
        aw_full           <= 1'b1;
        s_axi_awready_out <= 1'b0;
      end else if (wr_fire) begin
        aw_full <= 1'b0;
      end else if (!aw_full && !s_axi_bvalid_out) begin
        s_axi_awready_out <= 1'b1;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        wr_data          <= s_axi_wdata_in;
        wr_strb          <= s_axi_wstrb_in;
        w_full           <= 1'b1;
        s_axi_wready_out <= 1'b0;
      end else if (wr_fire) begin
        w_full <= 1'b0;
      end else if (!w_full && !s_axi_bvalid_out) begin
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  // Write response; unmapped offsets answer with a slave error.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= pulse_counter_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= mapped(wr_addr) ? pulse_counter_pkg::RESP_OKAY
                                          : pulse_counter_pkg::RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // Decoded single-cycle write strobes.
  logic wr_ctrl;
  logic wr_cmd;
  logic wr_fset;
  logic wr_fclr;
  logic load_count_now;
  logic load_top_now;
  assign wr_ctrl = wr_fire && wr_addr == pulse_counter_pkg::OFS_CONTROL;
  assign wr_cmd  = wr_fire && wr_addr == pulse_counter_pkg::OFS_COMMAND;
  assign wr_fset = wr_fire && wr_addr == pulse_counter_pkg::OFS_IRQ_FLAG_SET;
  assign wr_fclr = wr_fire && wr_addr == pulse_counter_pkg::OFS_IRQ_FLAG_CLR;
  assign load_count_now = wr_cmd && wr_word[pulse_counter_pkg::CMD_LOAD_CNT];
  assign load_top_now   = wr_cmd && wr_word[pulse_counter_pkg::CMD_LOAD_TOP];

  // Plain read-write configuration registers.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl        <= '0;
      top_buffer  <= pulse_counter_pkg::TOP_RESET;
      irq_enable  <= '0;
      pin_routing <= '0;
      freeze      <= 1'b0;
    end else if (wr_fire) begin
      unique case (wr_addr)
        pulse_counter_pkg::OFS_CONTROL:
          ctrl <= pulse_counter_pkg::ctrl_s'(
                    TW'(merge(32'(ctrl), wr_data, wr_strb)));
        pulse_counter_pkg::OFS_TOP_BUFFER:
          top_buffer <= CW'(merge(32'(top_buffer), wr_data, wr_strb));
        pulse_counter_pkg::OFS_IRQ_ENABLE:
          irq_enable <= FW'(merge(32'(irq_enable), wr_data, wr_strb));
        pulse_counter_pkg::OFS_PIN_ROUTING:
          pin_routing <= RW'(merge(32'(pin_routing), wr_data, wr_strb));
        pulse_counter_pkg::OFS_FREEZE:
          freeze <= 1'(merge(32'(freeze), wr_data, wr_strb));
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Input synchronisers and the low-frequency sampling tick.
  // ----------------------------------------------------------------------
  logic [1:0] pri_sync;
  logic [1:0] sec_sync;
  logic       pri_last;
  logic [15:0] lf_div;
  logic       lf_tick;

  // Pins are foreign to clk_in, so two stages come before any use.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pri_sync <= '0;
      sec_sync <= '0;
      pri_last <= 1'b0;
    end else begin
      pri_sync <= {pri_sync[0], primary_input_in};
      sec_sync <= {sec_sync[0], secondary_input_in};
      pri_last <= pri_sync[1];
    end
  end

  // Divider standing in for the 32 kHz sampling clock.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lf_div  <= '0;
      lf_tick <= 1'b0;
    end else begin
      lf_tick <= (lf_div == 16'(LF_DIVIDE - 1));
      lf_div  <= (lf_div == 16'(LF_DIVIDE - 1)) ? 16'h0000 : lf_div + 16'h0001;
    end
  end

  logic pri_rise;
  logic pri_fall;
  logic ext_mode;
  logic cnt_clk;
  assign pri_rise = pri_sync[1] && !pri_last;
  assign pri_fall = !pri_sync[1] && pri_last;
  assign ext_mode = ctrl.mode[1];
  // The counter domain's own clock: slow tick or primary input rising edges.
  assign cnt_clk  = ext_mode ? pri_rise : lf_tick;

  // ----------------------------------------------------------------------
  // Counter-domain reset with synchronous release.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      dom_rst     <= 1'b1;
      release_cnt <= '0;
    end else if (ctrl.domain_reset_hold) begin
      dom_rst     <= 1'b1;
      release_cnt <= '0;
    end else if (dom_rst && cnt_clk) begin
      if (release_cnt == 2'(pulse_counter_pkg::RELEASE_EDGES - 1)) begin
        dom_rst <= 1'b0;
      end
      release_cnt <= release_cnt + 2'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Oversampled path with the optional pulse-width filter.
  // ----------------------------------------------------------------------
  logic       ovs_level;
  logic       ovs_last;
  logic [2:0] pulse_filter_en_cnt;
  logic       pulse_filter_en_on;
  assign pulse_filter_en_on = ctrl.pulse_filter_en &&
                   ctrl.mode == pulse_counter_pkg::MODE_OVS_SINGLE;

  // With the filter on, a new level is accepted only after five equal slow samples.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ovs_level <= 1'b0;
      ovs_last  <= 1'b0;
      pulse_filter_en_cnt  <= '0;
    end else if (dom_rst) begin
      ovs_level <= 1'b0;
      ovs_last  <= 1'b0;
      pulse_filter_en_cnt  <= '0;
    end else if (lf_tick) begin
      ovs_last <= ovs_level;
      if (!pulse_filter_en_on) begin
        ovs_level <= pri_sync[1];
        pulse_filter_en_cnt  <= '0;
      end else if (pri_sync[1] == ovs_level) begin
        pulse_filter_en_cnt <= '0;
      end else if (pulse_filter_en_cnt == 3'(pulse_counter_pkg::PULSE_FILTER_EN_LEN - 1)) begin
        ovs_level <= pri_sync[1];
        pulse_filter_en_cnt  <= '0;
      end else begin
        pulse_filter_en_cnt <= pulse_filter_en_cnt + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Step decode for every mode.
  // ----------------------------------------------------------------------
  logic sec_at_edge;
  logic quad_up_edge;
  logic quad_dn_edge;
  logic step;
  logic step_down;

  // The secondary input is sampled on both primary edges.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sec_at_edge <= 1'b0;
    end else if (dom_rst) begin
      sec_at_edge <= 1'b0;
    end else if (pri_rise || pri_fall) begin
      sec_at_edge <= sec_sync[1];
    end
  end

  assign quad_up_edge = (pri_rise || pri_fall) && sec_sync[1] && !sec_at_edge;
  assign quad_dn_edge = (pri_rise || pri_fall) && !sec_sync[1] && sec_at_edge;

  always_comb begin
    step      = 1'b0;
    step_down = ctrl.count_direction;
    unique case (ctrl.mode)
      pulse_counter_pkg::MODE_DISABLED: step = 1'b0;
      pulse_counter_pkg::MODE_OVS_SINGLE:
        step = lf_tick && (ctrl.falling_polarity ?
                           (ovs_last && !ovs_level) :
                           (!ovs_last && ovs_level));
      pulse_counter_pkg::MODE_EXT_SINGLE: step = pri_rise;
      pulse_counter_pkg::MODE_QUAD: begin
        // One sampled secondary edge counts; nothing else moves.
        step      = quad_up_edge ^ quad_dn_edge;
        step_down = quad_up_edge ^ ctrl.falling_polarity;
      end
    endcase
    if (dom_rst) begin
      step = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Count, top value and direction status.
  // ----------------------------------------------------------------------
  logic uf_event;
  logic of_event;
  logic dirchg_event;
  assign uf_event = step && step_down && count == '0;
  assign of_event = step && !step_down && count == top_value;
  assign dirchg_event = step && ctrl.mode == pulse_counter_pkg::MODE_QUAD &&
                        step_down != dir_status;

  // Immediate loads win over a step arriving in the same cycle.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count      <= '0;
      top_value  <= pulse_counter_pkg::TOP_RESET;
      dir_status <= 1'b0;
    end else if (dom_rst) begin
      count      <= '0;
      top_value  <= pulse_counter_pkg::TOP_RESET;
      dir_status <= 1'b0;
    end else begin
      if (load_top_now) begin
        top_value <= top_buffer;
      end
      if (load_count_now) begin
        count <= top_buffer;
      end else if (uf_event) begin
        count <= top_value;
      end else if (of_event) begin
        count <= '0;
      end else if (step) begin
        count <= step_down ? count - 16'h0001 : count + 16'h0001;
      end
      if (step && ctrl.mode == pulse_counter_pkg::MODE_QUAD) begin
        dir_status <= step_down;
      end
    end
  end

  // Sticky flags: a hardware event beats a clear in the same cycle.
  logic [FW-1:0] hw_set;
  assign hw_set = {dirchg_event, of_event, uf_event};
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_flags <= '0;
    end else begin
      irq_flags <= ((irq_flags & ~({FW{wr_fclr}} & wr_word[FW-1:0]))
                   | hw_set
                   | ({FW{wr_fset}} & wr_word[FW-1:0]));
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read channel.
  // ----------------------------------------------------------------------
  function automatic logic [31:0] read_word(input logic [AW-1:0] a);
    unique case (a)
      pulse_counter_pkg::OFS_CONTROL:     return 32'(ctrl);
      pulse_counter_pkg::OFS_STATUS:      return 32'(dir_status);
      pulse_counter_pkg::OFS_COUNT_VALUE: return 32'(count);
      pulse_counter_pkg::OFS_TOP_VALUE:   return 32'(top_value);
      pulse_counter_pkg::OFS_TOP_BUFFER:  return 32'(top_buffer);
      pulse_counter_pkg::OFS_IRQ_FLAGS:   return 32'(irq_flags);
      pulse_counter_pkg::OFS_IRQ_ENABLE:  return 32'(irq_enable);
      pulse_counter_pkg::OFS_PIN_ROUTING: return 32'(pin_routing);
      pulse_counter_pkg::OFS_FREEZE:      return 32'(freeze);
      pulse_counter_pkg::OFS_SYNC_BUSY:   return 32'(dom_rst);
      default:                            return 32'h00000000;
    endcase
  endfunction

  // Write-only and unmapped words read as zero.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= '0;
      s_axi_rresp_out   <= pulse_counter_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= read_word(s_axi_araddr_in[AW-1:0]);
      s_axi_rresp_out   <= mapped(s_axi_araddr_in[AW-1:0]) ?
                           pulse_counter_pkg::RESP_OKAY :
                           pulse_counter_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid_out) begin
      if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end else begin
      s_axi_arready_out <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  AST_HOLD_RESETS: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    ctrl.domain_reset_hold |=> dom_rst)
    else $error("Counter domain not held in reset.");

  AST_RELEASE_COUNT: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    $fell(dom_rst) |->
    $past(release_cnt) == 2'(pulse_counter_pkg::RELEASE_EDGES - 1))
    else $error("Counter domain released after wrong edge count.");

  // A level taken while the filter was still off is no filter decision.
  AST_FILTER_LEN: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (pulse_filter_en_on && $past(pulse_filter_en_on) && !dom_rst && !$past(dom_rst) &&
     $changed(ovs_level))
    |-> $past(pulse_filter_en_cnt) == 3'(pulse_counter_pkg::PULSE_FILTER_EN_LEN - 1))
    else $error("Filtered level changed before five stable samples.");

  // Entering the domain reset clears the count; that is not a count.
  AST_DISABLED: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (ctrl.mode == pulse_counter_pkg::MODE_DISABLED && !wr_cmd && !dom_rst)
    |=> $stable(count))
    else $error("Count moved while disabled.");

  AST_UNDERFLOW: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (uf_event && !load_count_now && !dom_rst)
    |=> count == $past(top_value) && irq_flags[pulse_counter_pkg::FLAG_UF])
    else $error("Underflow did not reload top and set flag.");

  AST_OVERFLOW: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (of_event && !load_count_now && !dom_rst)
    |=> count == '0 && irq_flags[pulse_counter_pkg::FLAG_OF])
    else $error("Overflow did not clear count and set flag.");

  AST_LOAD_TOP: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (load_top_now && !dom_rst) |=> top_value == $past(top_buffer))
    else $error("Top value not loaded from buffer.");

  AST_FLAG_SET: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    wr_fset |=> (irq_flags & $past(wr_word[FW-1:0])) ==
                $past(wr_word[FW-1:0]))
    else $error("Flag set write did not set flags.");

  AST_FLAG_CLR: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (wr_fclr && hw_set == '0)
    |=> (irq_flags & $past(wr_word[FW-1:0])) == '0)
    else $error("Flag clear write did not clear flags.");

  AST_QUAD_DIR: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (ctrl.mode == pulse_counter_pkg::MODE_QUAD && step)
    |=> dir_status == ($past(quad_up_edge) ^ $past(ctrl.falling_polarity)))
    else $error("Quadrature direction mis-decoded.");

endmodule

//--- pulse_counter_pkg.sv
// Shared constants, register map and field layout of the pulse counter.
package pulse_counter_pkg;

  // ----------------------------------------------------------------------
  // Register offsets, relative to the block's base address.
  // ----------------------------------------------------------------------
  localparam int         ADDR_W          = 12;
  localparam logic [11:0] OFS_CONTROL     = 12'h000;
  localparam logic [11:0] OFS_COMMAND     = 12'h004;
  localparam logic [11:0] OFS_STATUS      = 12'h008;
  localparam logic [11:0] OFS_COUNT_VALUE = 12'h00C;
  localparam logic [11:0] OFS_TOP_VALUE   = 12'h010;
  localparam logic [11:0] OFS_TOP_BUFFER  = 12'h014;
  localparam logic [11:0] OFS_IRQ_FLAGS   = 12'h018;
  localparam logic [11:0] OFS_IRQ_FLAG_SET = 12'h01C;
  localparam logic [11:0] OFS_IRQ_FLAG_CLR = 12'h020;
  localparam logic [11:0] OFS_IRQ_ENABLE  = 12'h024;
  localparam logic [11:0] OFS_PIN_ROUTING = 12'h028;
  localparam logic [11:0] OFS_FREEZE      = 12'h02C;
  localparam logic [11:0] OFS_SYNC_BUSY   = 12'h030;

  // ----------------------------------------------------------------------
  // Field positions and widths.
  // ----------------------------------------------------------------------
  localparam int CTRL_W      = 6;
  localparam int CMD_LOAD_CNT = 0;
  localparam int CMD_LOAD_TOP = 1;
  localparam int FLAG_W      = 3;
  localparam int FLAG_UF     = 0;
  localparam int FLAG_OF     = 1;
  localparam int FLAG_DIRCHG = 2;
  localparam int ROUTE_W     = 3;
  localparam int CNT_W       = 16;
  localparam logic [15:0] TOP_RESET = 16'h00FF;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Timing: filter length, reset release and low-frequency tick.
  // ----------------------------------------------------------------------
  localparam int PULSE_FILTER_EN_LEN       = 5;
  localparam int RELEASE_EDGES  = 2;
  localparam int CLK_HZ         = 125000000;
  localparam int LF_HZ          = 32768;
  localparam int LF_DIV         = CLK_HZ / LF_HZ;

  typedef enum logic [1:0] {
    MODE_DISABLED   = 2'h0,
    MODE_OVS_SINGLE = 2'h1,
    MODE_EXT_SINGLE = 2'h2,
    MODE_QUAD       = 2'h3
  } mode_e;

  typedef struct packed {
    logic  domain_reset_hold;
    logic  pulse_filter_en;
    logic  falling_polarity;
    logic  count_direction;
    mode_e mode;
  } ctrl_s;

endpackage

//--- pulse_sensor.sv
// Sensor model: a two-phase pulse source driving both count pins.
`timescale 1ns/1ps
module pulse_sensor (
  input  wire logic clk_in,
  input  wire logic adv_in,
  output logic      primary_out,
  output logic      secondary_out
);
  logic [1:0] phase = 2'h0;
  // Gray steps move one pin at a time, like a real shaft encoder.
  always_ff @(posedge clk_in) begin
    if (adv_in)
      phase <= phase + 2'h1;
  end
  assign primary_out   = phase[1];
  assign secondary_out = phase[1] ^ phase[0];
endmodule

//--- tb_pulse_counter_control_regs.sv
// Self-checking bench of the pulse counter register block.
`timescale 1ns/1ps
module tb_pulse_counter_control_regs;
  // ------------------------------------------------------------------
  // Bus signals, clock and the sensor model.
  // ------------------------------------------------------------------
  logic        clk_in = 0, sys_rst_in = 1, adv = 0, pri, sec;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rr;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, rv;
  logic [19:0] base = 0;
  logic [15:0] t;
  int          n_fail = 0, total_checks = 0, n;
  // Free-running 125 MHz clock.
  always #4 clk_in = ~clk_in;
  pulse_sensor sensor_u (.clk_in(clk_in), .adv_in(adv), .primary_out(pri),
                         .secondary_out(sec));
  pulse_counter_control_regs #(.LF_DIVIDE(4)) dut_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .primary_input_in(pri),
    .secondary_input_in(sec), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready));
  // ------------------------------------------------------------------
  // Bus tasks, checks and the closing report.
  // ------------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Handshake levels by channel: aw, w, b, ar, r.
  function automatic logic lvl(int ch);
    logic [4:0] v;
    v = {rvalid, arready, bvalid, wready, awready};
    return v[ch];
  endfunction
  // Waits at sampling edges only, so no valid drops before its take.
  task automatic await(int ch);
    int i = 0;
    do begin
      @(posedge clk_in);
      i++;
    end while (lvl(ch) !== 1'b1 && i < 300);
    if (lvl(ch) !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    awaddr <= {base, a};
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    fork
      begin
        await(0);
        awvalid <= 0;
      end
      begin
        await(1);
        wvalid <= 0;
      end
    join
    bready <= 1;
    await(2);
    bready <= 0;
  endtask
  task automatic rd(logic [11:0] a);
    araddr <= {base, a};
    arvalid <= 1;
    await(3);
    arvalid <= 0;
    rready <= 1;
    await(4);
    rready <= 0;
    rv = rdata;
    rr = rresp;
  endtask
  // Expected count after k up steps from c, wrapping past top to zero.
  function automatic int up_cnt(int c, int top, int k);
    repeat (k) c = (c == top) ? 0 : c + 1;
    return c;
  endfunction
  task automatic rchk(string nm, logic [11:0] a, logic [31:0] exp);
    rd(a);
    chk(nm, rv, exp);
  endtask
  // Sensor steps of h+1 clocks each; four steps make one whole pulse.
  task automatic pulse(int h, int k = 4);
    repeat (k) begin
      adv <= 1;
      @(posedge clk_in);
      adv <= 0;
      repeat (h) @(posedge clk_in);
    end
  endtask
  // ------------------------------------------------------------------
  // Main sequence, all accesses at a random block base.
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(51));
    base = 20'($urandom);
    t = 16'(3 + $urandom % 8);
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 0;
    @(posedge clk_in);
    rchk("control", pulse_counter_pkg::OFS_CONTROL, 0);
    rchk("top", pulse_counter_pkg::OFS_TOP_VALUE, 32'h00FF);
    // Slow ticks release the domain soon after reset, so hold it again.
    wr(pulse_counter_pkg::OFS_CONTROL, 32'h22);
    rchk("busy", pulse_counter_pkg::OFS_SYNC_BUSY, 1);
    wr(pulse_counter_pkg::OFS_CONTROL, 32'h02);
    pulse(6);
    pulse(6);
    rchk("busy", pulse_counter_pkg::OFS_SYNC_BUSY, 0);
    n = 1 + $urandom % 8;
    repeat (n) pulse(6);
    rchk("count", pulse_counter_pkg::OFS_COUNT_VALUE,
         up_cnt(0, pulse_counter_pkg::TOP_RESET, n));
    wr(pulse_counter_pkg::OFS_TOP_BUFFER, {16'h0, t});
    wr(pulse_counter_pkg::OFS_COMMAND, 32'h2);
    rchk("top", pulse_counter_pkg::OFS_TOP_VALUE, {16'h0, t});
    wr(pulse_counter_pkg::OFS_COMMAND, 32'h1);
    rchk("count", pulse_counter_pkg::OFS_COUNT_VALUE, t);
    pulse(6);
    rchk("count", pulse_counter_pkg::OFS_COUNT_VALUE,
         up_cnt(t, t, 1));
    rchk("flags", pulse_counter_pkg::OFS_IRQ_FLAGS, 2);
    wr(pulse_counter_pkg::OFS_CONTROL, 32'h06);
    pulse(6);
    rchk("count", pulse_counter_pkg::OFS_COUNT_VALUE, t);
    rchk("flags", pulse_counter_pkg::OFS_IRQ_FLAGS, 3);
    pulse(6);
    rchk("count", pulse_counter_pkg::OFS_COUNT_VALUE, t - 1);
    wr(pulse_counter_pkg::OFS_IRQ_FLAG_CLR, 32'h2);
    rchk("flags", pulse_counter_pkg::OFS_IRQ_FLAGS, 1);
    wr(pulse_counter_pkg::OFS_IRQ_FLAG_SET, 32'h4);
    rchk("flags", pulse_counter_pkg::OFS_IRQ_FLAGS, 5);
    rd(12'h034);
    chk("resp", {30'h0, rr}, {30'h0, pulse_counter_pkg::RESP_SLVERR});
    wr(pulse_counter_pkg::OFS_CONTROL, 32'h00);
    pulse(6);
    rchk("count", pulse_counter_pkg::OFS_COUNT_VALUE, t - 1);
    // Filtered slow sampling: a short glitch dies, a long pulse counts.
    wr(pulse_counter_pkg::OFS_CONTROL, 32'h11);
    pulse(2);
    rchk("count", pulse_counter_pkg::OFS_COUNT_VALUE, t - 1);
    pulse(40);
    rchk("count", pulse_counter_pkg::OFS_COUNT_VALUE, t);
    // Polarity is only changed while the counter is disabled.
    wr(pulse_counter_pkg::OFS_CONTROL, 32'h00);
    wr(pulse_counter_pkg::OFS_CONTROL, 32'h19);
    pulse(40, 2);
    rchk("count", pulse_counter_pkg::OFS_COUNT_VALUE, t);
    pulse(40, 2);
    rchk("count", pulse_counter_pkg::OFS_COUNT_VALUE, 0);
    // Quadrature: a half pulse gives one primary edge; direction bit set.
    wr(pulse_counter_pkg::OFS_CONTROL, 32'h00);
    wr(pulse_counter_pkg::OFS_CONTROL, 32'h07);
    wr(pulse_counter_pkg::OFS_IRQ_FLAG_CLR, 32'h7);
    pulse(6, 2);
    rchk("count", pulse_counter_pkg::OFS_COUNT_VALUE, t);
    rchk("status", pulse_counter_pkg::OFS_STATUS, 1);
    rchk("flags", pulse_counter_pkg::OFS_IRQ_FLAGS, 5);
    pulse(6, 2);
    rchk("status", pulse_counter_pkg::OFS_STATUS, 0);
    rchk("count", pulse_counter_pkg::OFS_COUNT_VALUE, 0);
    // The held domain restores top two clocks after the write lands.
    wr(pulse_counter_pkg::OFS_CONTROL, 32'h20);
    repeat (2) @(posedge clk_in);
    rchk("top", pulse_counter_pkg::OFS_TOP_VALUE, 32'h00FF);
    print_verdict();
  end
endmodule
